/* File: rtl/dpr_pkg.sv */
// shared constants for the dual-port block memory
// assumes one clock domain; both ports and the fabric run on it
package dpr_pkg;
    localparam int ROWS        = 512;  // rows of the shared array
    localparam int ROW_AW      = 9;    // row index width
    localparam int ROW_DATA    = 32;   // data bits per row
    localparam int ROW_EXTRA   = 4;    // extra bits per row, one per byte lane
    localparam int ROW_W       = ROW_DATA + ROW_EXTRA;
    localparam int LANES       = 4;
    localparam int LANE_BITS   = 8;
    localparam int MAX_AW      = 14;   // 16K x1 needs the widest address
    localparam int OFF_W       = 5;    // bit offset inside a row
    localparam int WE_W        = 4;
    localparam int MULT_SHARED = 16;   // input bits that share routing with the multiplier
    localparam int WIDE_DW     = 32;   // widest organisation, the one that collides

    // feature level of the memory
    localparam int VAR_BASE   = 0;     // single write enable
    localparam int VAR_BYTEWE = 1;     // byte-lane write enables
    localparam int VAR_OUTREG = 2;     // byte-lane enables plus output register

    // log2 of how many port words fit in one row
    function automatic int row_shift(input int dw);
        int s;
        s = 0;
        while ((ROW_DATA >> s) > dw) begin
            s = s + 1;
        end
        return s;
    endfunction : row_shift

    function automatic bit legal_width(input int dw);
        return dw == 1 || dw == 2 || dw == 4 || dw == 8 || dw == 16 || dw == 32;
    endfunction : legal_width
endpackage : dpr_pkg

/* File: rtl/dpr_port.sv */
// one access port: address mapping, write masks, read latch, output register
// assumes the parent holds the array and hands back the addressed row unwritten
`timescale 1ns/10ps
module dpr_port #(
    parameter int                    DW          = 32,
    parameter int                    VARIANT     = dpr_pkg::VAR_BASE,
    parameter bit                    OUTREG      = 1'b0,
    parameter bit                    CLEAR_ASYNC = 1'b0,
    parameter logic [dpr_pkg::ROW_W-1:0] PRESET_VAL = '0
) (
    // clock and reset
    input  wire logic                            clock,
    input  wire logic                            rst,
    // fabric side
    input  wire logic                            en,
    input  wire logic [dpr_pkg::WE_W-1:0]        we,
    input  wire logic [dpr_pkg::MAX_AW-1:0]      addr,
    input  wire logic [dpr_pkg::ROW_DATA-1:0]    write_data_in,
    input  wire logic [dpr_pkg::ROW_EXTRA-1:0]   extra_bits_in,
    input  wire logic                            sync_output_preset,
    input  wire logic                            outreg_clear,
    input  wire logic                            outreg_gate,
    output logic      [dpr_pkg::ROW_DATA-1:0]    read_data_out,
    output logic      [dpr_pkg::ROW_EXTRA-1:0]   extra_bits_out,
    // array side
    input  wire logic [dpr_pkg::ROW_W-1:0]       row_q,
    output logic      [dpr_pkg::ROW_AW-1:0]      row_idx,
    output logic      [dpr_pkg::ROW_W-1:0]       wr_mask,
    output logic      [dpr_pkg::ROW_W-1:0]       wr_word,
    output logic                                 wr_act
);
    localparam int SH  = dpr_pkg::row_shift(DW);
    localparam int EW  = (DW >= dpr_pkg::LANE_BITS) ? DW / dpr_pkg::LANE_BITS : 0;
    localparam logic [dpr_pkg::OFF_W-1:0]     SUB_MASK = dpr_pkg::OFF_W'((1 << SH) - 1);
    localparam logic [dpr_pkg::ROW_DATA-1:0]  D_MASK   = dpr_pkg::ROW_DATA'((64'd1 << DW) - 1);
    localparam logic [dpr_pkg::ROW_EXTRA-1:0] E_MASK   = dpr_pkg::ROW_EXTRA'((1 << EW) - 1);
    // preset keeps only the bits this width owns, so narrow ports still read zero above
    localparam logic [dpr_pkg::ROW_W-1:0]     PRE_Q    = PRESET_VAL & {E_MASK, D_MASK};

    if (!dpr_pkg::legal_width(DW)) begin : g_bad_width
        $error("port data width must be 1, 2, 4, 8, 16 or 32");
    end
    if (OUTREG && VARIANT != dpr_pkg::VAR_OUTREG) begin : g_bad_outreg
        $error("output register exists only on the top feature level");
    end

    logic [dpr_pkg::OFF_W-1:0]     sub_w;
    logic [dpr_pkg::OFF_W-1:0]     off_w;
    logic [1:0]                    lane_w;
    logic [dpr_pkg::LANES-1:0]     lane_we;
    logic [dpr_pkg::ROW_DATA-1:0]  lane_bits;
    logic [dpr_pkg::ROW_DATA-1:0]  rd_data;
    logic [dpr_pkg::ROW_EXTRA-1:0] rd_extra;
    logic [dpr_pkg::ROW_W-1:0]     latch_ff;
    logic [dpr_pkg::ROW_W-1:0]     oreg_ff;
    logic                          oreg_arst;

    // each port folds its own address onto the shared rows by its width
    assign row_idx = dpr_pkg::ROW_AW'(addr >> SH);
    assign sub_w   = addr[dpr_pkg::OFF_W-1:0] & SUB_MASK;
    assign off_w   = dpr_pkg::OFF_W'(sub_w * DW);
    assign lane_w  = off_w[dpr_pkg::OFF_W-1:3];

    // baseline keeps one enable for the whole word; higher levels use one per byte lane, except below byte width
    assign lane_we = (VARIANT == dpr_pkg::VAR_BASE || EW == 0) ?
                     {dpr_pkg::LANES{we[0]}} : we;
    assign lane_bits = {{dpr_pkg::LANE_BITS{lane_we[3]}}, {dpr_pkg::LANE_BITS{lane_we[2]}},
                        {dpr_pkg::LANE_BITS{lane_we[1]}}, {dpr_pkg::LANE_BITS{lane_we[0]}}};

    // extra bits sit above the data bits in the row; none below byte width
    assign wr_mask = {dpr_pkg::ROW_EXTRA'(E_MASK << lane_w) & lane_we,
                      dpr_pkg::ROW_DATA'(D_MASK << off_w) & lane_bits};
    assign wr_word = {dpr_pkg::ROW_EXTRA'(extra_bits_in << lane_w),
                      dpr_pkg::ROW_DATA'(write_data_in << off_w)};
    assign wr_act  = en & (|lane_we);

    assign rd_data  = dpr_pkg::ROW_DATA'(row_q[dpr_pkg::ROW_DATA-1:0] >> off_w) & D_MASK;
    assign rd_extra = dpr_pkg::ROW_EXTRA'(row_q[dpr_pkg::ROW_W-1:dpr_pkg::ROW_DATA] >> lane_w)
                      & E_MASK;

    // read is synchronous; row_q is the pre-write value, so a write reads old data
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            latch_ff <= '0;
        end else if (en) begin
            latch_ff <= sync_output_preset ? PRE_Q : {rd_extra, rd_data};
        end
    end

    // async clear form shares the flop reset; glitches on the clear will hit it
    assign oreg_arst = rst | (CLEAR_ASYNC & outreg_clear);

    always_ff @(posedge clock or posedge oreg_arst) begin
        if (oreg_arst) begin
            oreg_ff <= '0;
        end else if (outreg_clear) begin
            oreg_ff <= '0;
        end else if (outreg_gate) begin
            oreg_ff <= latch_ff;
        end
    end

    // constant select: the chosen stage is a flop either way
    assign read_data_out  = OUTREG ? oreg_ff[dpr_pkg::ROW_DATA-1:0]
                                   : latch_ff[dpr_pkg::ROW_DATA-1:0];
    assign extra_bits_out = OUTREG ? oreg_ff[dpr_pkg::ROW_W-1:dpr_pkg::ROW_DATA]
                                   : latch_ff[dpr_pkg::ROW_W-1:dpr_pkg::ROW_DATA];
endmodule : dpr_port

/* File: rtl/dpr_top.sv */
// dual-port block memory: one shared array of 512 rows of 36 bits, two ports
// assumes both ports are driven by fabric logic on the same clock
`timescale 1ns/10ps
module dpr_top #(
    parameter int                        A_WIDTH        = 32,
    parameter int                        B_WIDTH        = 32,
    parameter int                        VARIANT        = dpr_pkg::VAR_BASE,
    parameter bit                        A_OUTREG       = 1'b0,
    parameter bit                        B_OUTREG       = 1'b0,
    parameter bit                        A_CLEAR_ASYNC  = 1'b0,
    parameter bit                        B_CLEAR_ASYNC  = 1'b0,
    parameter logic [dpr_pkg::ROW_W-1:0] A_PRESET_VAL   = '0,
    parameter logic [dpr_pkg::ROW_W-1:0] B_PRESET_VAL   = '0
) (
    // clock and reset
    input  wire logic                            clock,
    input  wire logic                            rst,
    // port a
    input  wire logic                            port_a_en,
    input  wire logic [dpr_pkg::WE_W-1:0]        port_a_we,
    input  wire logic [dpr_pkg::MAX_AW-1:0]      port_a_addr,
    input  wire logic [dpr_pkg::ROW_DATA-1:0]    port_a_write_data_in,
    input  wire logic [dpr_pkg::ROW_EXTRA-1:0]   port_a_extra_bits_in,
    input  wire logic                            port_a_sync_output_preset,
    input  wire logic                            port_a_output_clear,
    input  wire logic                            port_a_outreg_gate,
    output logic      [dpr_pkg::ROW_DATA-1:0]    port_a_read_data_out,
    output logic      [dpr_pkg::ROW_EXTRA-1:0]   port_a_extra_bits_out,
    // port b
    input  wire logic                            port_b_en,
    input  wire logic [dpr_pkg::WE_W-1:0]        port_b_we,
    input  wire logic [dpr_pkg::MAX_AW-1:0]      port_b_addr,
    input  wire logic [dpr_pkg::ROW_DATA-1:0]    port_b_write_data_in,
    input  wire logic [dpr_pkg::ROW_EXTRA-1:0]   port_b_extra_bits_in,
    input  wire logic                            port_b_sync_output_preset,
    input  wire logic                            port_b_output_clear,
    input  wire logic                            port_b_outreg_gate,
    output logic      [dpr_pkg::ROW_DATA-1:0]    port_b_read_data_out,
    output logic      [dpr_pkg::ROW_EXTRA-1:0]   port_b_extra_bits_out,
    // routing status
    output logic                                 mult_blocked_ff
);
    if (VARIANT < dpr_pkg::VAR_BASE || VARIANT > dpr_pkg::VAR_OUTREG) begin : g_bad_variant
        $error("feature level must be 0, 1 or 2");
    end
    if ((A_CLEAR_ASYNC || B_CLEAR_ASYNC) && VARIANT != dpr_pkg::VAR_OUTREG) begin : g_bad_clr
        $error("asynchronous output clear exists only on the top feature level");
    end

    // row layout: [35:32] extra bits, [31:0] data
    logic [dpr_pkg::ROW_W-1:0]  mem [dpr_pkg::ROWS];

    logic [dpr_pkg::ROW_AW-1:0] a_row;
    logic [dpr_pkg::ROW_AW-1:0] b_row;
    logic [dpr_pkg::ROW_W-1:0]  a_mask;
    logic [dpr_pkg::ROW_W-1:0]  b_mask;
    logic [dpr_pkg::ROW_W-1:0]  a_word;
    logic [dpr_pkg::ROW_W-1:0]  b_word;
    logic                       a_wr;
    logic                       b_wr;
    logic [dpr_pkg::ROW_W-1:0]  a_q;
    logic [dpr_pkg::ROW_W-1:0]  b_q;
    logic [dpr_pkg::ROW_W-1:0]  a_new;
    logic [dpr_pkg::ROW_W-1:0]  b_base;
    logic [dpr_pkg::ROW_W-1:0]  b_new;
    logic                       same_row;
    logic                       nxt_mult_blocked;

    // both ports see the array before this edge's writes
    assign a_q = mem[a_row];
    assign b_q = mem[b_row];

    dpr_port #(
        .DW          (A_WIDTH),
        .VARIANT     (VARIANT),
        .OUTREG      (A_OUTREG),
        .CLEAR_ASYNC (A_CLEAR_ASYNC),
        .PRESET_VAL  (A_PRESET_VAL)
    ) u_port_a (
        .clock              (clock),
        .rst                (rst),
        .en                 (port_a_en),
        .we                 (port_a_we),
        .addr               (port_a_addr),
        .write_data_in      (port_a_write_data_in),
        .extra_bits_in      (port_a_extra_bits_in),
        .sync_output_preset (port_a_sync_output_preset),
        .outreg_clear       (port_a_output_clear),
        .outreg_gate        (port_a_outreg_gate),
        .read_data_out      (port_a_read_data_out),
        .extra_bits_out     (port_a_extra_bits_out),
        .row_q              (a_q),
        .row_idx            (a_row),
        .wr_mask            (a_mask),
        .wr_word            (a_word),
        .wr_act             (a_wr)
    );

    dpr_port #(
        .DW          (B_WIDTH),
        .VARIANT     (VARIANT),
        .OUTREG      (B_OUTREG),
        .CLEAR_ASYNC (B_CLEAR_ASYNC),
        .PRESET_VAL  (B_PRESET_VAL)
    ) u_port_b (
        .clock              (clock),
        .rst                (rst),
        .en                 (port_b_en),
        .we                 (port_b_we),
        .addr               (port_b_addr),
        .write_data_in      (port_b_write_data_in),
        .extra_bits_in      (port_b_extra_bits_in),
        .sync_output_preset (port_b_sync_output_preset),
        .outreg_clear       (port_b_output_clear),
        .outreg_gate        (port_b_outreg_gate),
        .read_data_out      (port_b_read_data_out),
        .extra_bits_out     (port_b_extra_bits_out),
        .row_q              (b_q),
        .row_idx            (b_row),
        .wr_mask            (b_mask),
        .wr_word            (b_word),
        .wr_act             (b_wr)
    );

    // masked merges; when both write one row, b lands on top of a's bits
    assign a_new    = (a_q & ~a_mask) | (a_word & a_mask);
    assign same_row = a_wr && (a_row == b_row);
    assign b_base   = same_row ? a_new : b_q;
    assign b_new    = (b_base & ~b_mask) | (b_word & b_mask);

    // both ports write in the same edge; on a shared row only b writes, carrying a's merged bits           
    always_ff @(posedge clock) begin
        if (a_wr && !(b_wr && a_row == b_row)) begin
            mem[a_row] <= a_new;
        end
        if (b_wr) begin
            mem[b_row] <= b_new;
        end
    end

    // a baseline port at full width takes the multiplier's shared input wiring
    assign nxt_mult_blocked = (VARIANT == dpr_pkg::VAR_BASE) &&
                              (A_WIDTH == dpr_pkg::WIDE_DW || B_WIDTH == dpr_pkg::WIDE_DW);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mult_blocked_ff <= 1'b0;
        end else begin
            mult_blocked_ff <= nxt_mult_blocked;
        end
    end
endmodule : dpr_top

/* File: dv/dpr_fabric.sv */
// fabric-side driver model for port b of the dual-port memory
// assumes the bench changes go/wr/ad/wd just after a rising clock edge
`timescale 1ns/10ps
module dpr_fabric (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // bench requests
    input  wire logic        go,
    input  wire logic        wr,
    input  wire logic [13:0] ad,
    input  wire logic [8:0]  wd,
    // memory port pins
    output logic             en,
    output logic      [3:0]  we,
    output logic      [13:0] addr,
    output logic      [31:0] wdata,
    output logic      [3:0]  xin
);
    logic [8:0] last_ff;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) last_ff <= 9'h0;
        else if (go) last_ff <= wd;
    end
    assign en    = go;
    assign we    = (go && wr) ? 4'hF : 4'h0;
    assign addr  = ad;
    // idle data lines show the inverse, so stale values never look valid
    assign wdata = {24'h0, go ? wd[7:0] : ~last_ff[7:0]};
    assign xin   = {3'h0, go ? wd[8] : ~last_ff[8]};
endmodule : dpr_fabric

/* File: dv/dpr_checker_assertions.sv */
// port-level checks for the dual-port memory top
// assumes a 32 wide plain port a and an 8 wide port b with output register, top level
`timescale 1ns/10ps
module dpr_checker #(
    parameter logic [35:0] A_PRESET_VAL = '0
) (
    // clock and reset
    input wire logic        clock,
    input wire logic        rst,
    // port a
    input wire logic        port_a_en,
    input wire logic [3:0]  port_a_we,
    input wire logic [13:0] port_a_addr,
    input wire logic [31:0] port_a_write_data_in,
    input wire logic [3:0]  port_a_extra_bits_in,
    input wire logic        port_a_sync_output_preset,
    input wire logic [31:0] port_a_read_data_out,
    input wire logic [3:0]  port_a_extra_bits_out,
    // port b
    input wire logic        port_b_en,
    input wire logic        port_b_output_clear,
    input wire logic        port_b_outreg_gate,
    input wire logic [31:0] port_b_read_data_out,
    input wire logic [3:0]  port_b_extra_bits_out,
    // status
    input wire logic        mult_blocked_ff
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    a_hold_idle: assert property (!port_a_en |=>
        $stable({port_a_extra_bits_out, port_a_read_data_out}))
        else $error("port a output moved while disabled");
    a_preset_load: assert property (port_a_en && port_a_sync_output_preset |=>
        {port_a_extra_bits_out, port_a_read_data_out} == A_PRESET_VAL)
        else $error("port a preset value wrong");
    a_store_fetch: assert property (
        port_a_en && port_a_we == 4'hF && !port_b_en ##1 port_a_en && port_a_we == 4'h0
        && !port_a_sync_output_preset && port_a_addr == $past(port_a_addr)
        |=> {port_a_extra_bits_out, port_a_read_data_out}
        == $past({port_a_extra_bits_in, port_a_write_data_in}, 2))
        else $error("port a read back differs from write");
    a_gate_hold: assert property (!port_b_outreg_gate && !port_b_output_clear |=>
        $stable({port_b_extra_bits_out, port_b_read_data_out}))
        else $error("port b register loaded with gate low");
    a_b_idle_hold: assert property (
        (!port_b_en && port_b_outreg_gate && !port_b_output_clear) [*2] |=>
        $stable({port_b_extra_bits_out, port_b_read_data_out}))
        else $error("port b output moved while disabled");
    a_clear_zero: assert property (port_b_output_clear |=>
        {port_b_extra_bits_out, port_b_read_data_out} == 36'h0)
        else $error("port b clear left bits set");
    a_narrow_pad: assert property (port_b_read_data_out[31:8] == 24'h0
        && port_b_extra_bits_out[3:1] == 3'h0)
        else $error("port b unused output bits set");
    a_mult_free: assert property (mult_blocked_ff == 1'b0)
        else $error("multiplier flagged blocked on top level");
endmodule : dpr_checker
bind dpr_top dpr_checker #(.A_PRESET_VAL(A_PRESET_VAL)) u_chk (
    .clock(clock), .rst(rst), .port_a_en(port_a_en), .port_a_we(port_a_we),
    .port_a_addr(port_a_addr), .port_a_write_data_in(port_a_write_data_in),
    .port_a_extra_bits_in(port_a_extra_bits_in),
    .port_a_sync_output_preset(port_a_sync_output_preset),
    .port_a_read_data_out(port_a_read_data_out), .port_a_extra_bits_out(port_a_extra_bits_out),
    .port_b_en(port_b_en), .port_b_output_clear(port_b_output_clear),
    .port_b_outreg_gate(port_b_outreg_gate), .port_b_read_data_out(port_b_read_data_out),
    .port_b_extra_bits_out(port_b_extra_bits_out), .mult_blocked_ff(mult_blocked_ff));

/* File: dv/dpr_top_bench.sv */
// self-checking bench: port a 32 wide plain, port b 8 wide through the fabric model
// assumes one 200 MHz clock; only rows 0..15 are used and mirrored here
`timescale 1ns/10ps
module dpr_top_bench;
    localparam logic [35:0] PV  = 36'h9A5A51234;
    localparam logic [35:0] BPV = 36'h65A5AEDCB;
    logic        clock, rst, a_en, a_pre, b_go, b_wr, b_gate, b_clr, b_en, mb, b_pre;
    logic [3:0]  a_we, a_x, a_xo, b_we, b_xi, b_xo;
    logic [13:0] a_ad, b_ad, b_addr;
    logic [31:0] a_wd, a_rd, b_wdat, b_rd, seed;
    logic [8:0]  b_wd;
    logic [35:0] mem [16];
    int          miscompares, n_compared, cyc;
    dpr_fabric u_fab (.clock(clock), .rst(rst), .go(b_go), .wr(b_wr), .ad(b_ad), .wd(b_wd),
        .en(b_en), .we(b_we), .addr(b_addr), .wdata(b_wdat), .xin(b_xi));
    dpr_top #(.A_WIDTH(32), .B_WIDTH(8), .VARIANT(dpr_pkg::VAR_OUTREG), .B_OUTREG(1'b1),
        .A_PRESET_VAL(PV), .B_PRESET_VAL(BPV)) u_dut (.clock(clock), .rst(rst),
        .port_a_en(a_en),
        .port_a_we(a_we), .port_a_addr(a_ad), .port_a_write_data_in(a_wd),
        .port_a_extra_bits_in(a_x), .port_a_sync_output_preset(a_pre),
        .port_a_output_clear(b_clr), .port_a_outreg_gate(b_gate), .port_a_read_data_out(a_rd),
        .port_a_extra_bits_out(a_xo), .port_b_en(b_en), .port_b_we(b_we),
        .port_b_addr(b_addr), .port_b_write_data_in(b_wdat), .port_b_extra_bits_in(b_xi),
        .port_b_sync_output_preset(b_pre), .port_b_output_clear(b_clr),
        .port_b_outreg_gate(b_gate), .port_b_read_data_out(b_rd),
        .port_b_extra_bits_out(b_xo), .mult_blocked_ff(mb));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [35:0] merge(logic [35:0] o, logic [3:0] we, logic [35:0] w);
        for (int i = 0; i < 4; i++) if (we[i]) begin
            o[8*i+:8] = w[8*i+:8];
            o[32+i]   = w[32+i];
        end
        return o;
    endfunction : merge
    function automatic logic [35:0] bsel(logic [35:0] r, logic [1:0] k);
        return {3'h0, r[32+k], 24'h0, r[8*k+:8]};
    endfunction : bsel
    task check(input logic [35:0] seen, input logic [35:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task close_out;
        if (miscompares == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : close_out
    task a_set(input logic e, input logic [3:0] we, input logic [3:0] r, input logic [35:0] w);
        a_en <= e; a_we <= we; a_ad <= {10'h0, r}; a_wd <= w[31:0]; a_x <= w[35:32];
    endtask : a_set
    task b_set(input logic g, input logic w, input logic [5:0] ad, input logic [8:0] d);
        b_go <= g; b_wr <= w; b_ad <= {8'h0, ad}; b_wd <= d;
    endtask : b_set
    // read row r on port a and compare with the mirror 1 ns after the edge that takes it
    task a_read(input logic [3:0] r);
        @(posedge clock); a_set(1'b1, 4'h0, r, 36'h0);
        @(posedge clock); a_set(1'b0, 4'h0, r, 36'h0);
        #1 check({a_xo, a_rd}, mem[r]);
    endtask : a_read
    initial begin clock = 1'b0; forever #2.5 clock = ~clock; end
    always @(posedge clock) begin
        cyc++;
        if (cyc == 3000) begin miscompares++; close_out(); end
    end
    initial begin
        logic [35:0] w, pb;
        logic [3:0]  r, q, we;
        logic [1:0]  k;
        rst = 1'b1; seed = 32'h6; a_pre = 1'b0; b_gate = 1'b1; b_clr = 1'b0; pb = 36'h0;
        b_pre = 1'b0;
        a_set(1'b0, 4'h0, 4'h0, 36'h0); b_set(1'b0, 1'b0, 6'h0, 9'h0);
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            w = 36'({rnd(), rnd()}); mem[i] = w;
            @(posedge clock); a_set(1'b1, 4'hF, 4'(i), w);
            a_read(4'(i));
        end
        repeat (30) begin
            w = 36'({rnd(), rnd()}); we = 4'(rnd()); r = 4'(rnd()); k = 2'(rnd());
            q = r ^ 4'h8 ^ {2'h0, k};
            @(posedge clock); a_set(1'b1, we, r, w); b_set(1'b1, 1'b0, {q, k}, 9'h0);
            @(posedge clock); a_set(1'b0, 4'h0, r, 36'h0); b_set(1'b0, 1'b0, {q, k}, 9'h0);
            mem[r] = merge(mem[r], we, w);
            #1 check({b_xo, b_rd}, pb);
            @(posedge clock); pb = bsel(mem[q], k);
            #1 check({b_xo, b_rd}, pb);
            a_read(r);
            @(posedge clock); b_set(1'b1, 1'b1, {q, k}, w[8:0]);
            @(posedge clock); b_set(1'b0, 1'b0, {q, k}, 9'h0);
            mem[q][8*k+:8] = w[7:0]; mem[q][32+k] = w[8];
            a_read(q);
        end
        // a write attempt with the port disabled must leave the row alone
        @(posedge clock); a_set(1'b0, 4'hF, 4'h3, ~mem[3]);
        a_read(4'h3);
        @(posedge clock); a_set(1'b1, 4'h0, 4'h1, 36'h0); a_pre <= 1'b1;
        @(posedge clock); a_set(1'b0, 4'h0, 4'h1, 36'h0); a_pre <= 1'b0;
        #1 check({a_xo, a_rd}, PV);
        @(posedge clock); b_gate <= 1'b0; b_set(1'b1, 1'b0, 6'h16, 9'h0);
        @(posedge clock); b_set(1'b0, 1'b0, 6'h16, 9'h0);
        repeat (2) @(posedge clock);
        #1 check({b_xo, b_rd}, pb);
        @(posedge clock); b_gate <= 1'b1; b_clr <= 1'b1;
        @(posedge clock); b_clr <= 1'b0;
        #1 check({b_xo, b_rd}, 36'h0);
        // preset through the register: only the bits an 8 wide port owns may show
        @(posedge clock); b_pre <= 1'b1; b_set(1'b1, 1'b0, 6'h0, 9'h0);
        @(posedge clock); b_pre <= 1'b0; b_set(1'b0, 1'b0, 6'h0, 9'h0);
        @(posedge clock);
        #1 check({b_xo, b_rd}, bsel(BPV, 2'h0));
        check({35'h0, mb}, 36'h0);
        close_out();
    end
endmodule : dpr_top_bench
